// ===== hpc_cfg.svh
// Constants of the host port pin configuration block: register offsets,
// field positions, reset values, pin roles and bus timing.
// Assumes inclusion by both ends and by the verification side.
`ifndef HPC_CFG_SVH
`define HPC_CFG_SVH

// Register offsets on the core-side port
`define HPC_OFF_CTRL 24'hFFFFC4
`define HPC_OFF_DIR 24'hFFFFC8
`define HPC_OFF_DATA 24'hFFFFC9
`define HPC_OFF_AUX 24'hFFFFCA
`define HPC_OFF_VEC 24'hFFFFCB
`define HPC_OFF_STAT 24'hFFFFCC

// Control register fields
`define HPC_B_GEN 0
`define HPC_B_A8EN 1
`define HPC_B_A9EN 2
`define HPC_B_CSEN 3
`define HPC_B_REN 4
`define HPC_B_AEN 5
`define HPC_B_EN 6
`define HPC_B_ROD 8
`define HPC_B_DSP 9
`define HPC_B_ASP 10
`define HPC_B_MUX 11
`define HPC_B_DDS 12
`define HPC_B_CSP 13
`define HPC_B_RP 14
`define HPC_B_AP 15
`define HPC_CTRL_MASK 16'hFF7F

// Auxiliary register fields: host read byte, request mode, requests
`define HPC_AUX_DRQ 8
`define HPC_AUX_TXR 9
`define HPC_AUX_RXR 10
`define HPC_AUX_MASK 16'h07FF

// Reset values
`define HPC_CTRL_RST 16'h0000
`define HPC_DIR_RST 16'h0000
`define HPC_AUX_RST 16'h0000

// Pin roles: 7..0 data or address/data, 10..8 address lines, 8 address strobe when multiplexed
`define HPC_P_AS 8
`define HPC_P_CS 11
`define HPC_P_RW 12
`define HPC_P_DS 13
`define HPC_P_REQ 14
`define HPC_P_ACK 15

// Host bus timing in ns: clock period and the length of each phase
`define HPC_CLK_NS 20
`define HPC_PHASE_NS 160

`endif

// ===== hpc_pkg.sv
// Types shared by both ends of the host port link.
// Assumes hpc_cfg.svh supplies the numeric constants.
package hpc_pkg;

  // Device end state, registered as a whole
  typedef struct packed {
    logic [15:0] ctrl;
    logic [15:0] dir;
    logic [15:0] dout;
    logic [15:0] aux;
    logic [7:0] vec;
    logic [15:0] s1;
    logic [15:0] s2;
    logic wr_d;
    logic rd_d;
    logic [2:0] addr;
    logic [7:0] wbyte;
    logic [15:0] pin_o;
    logic [15:0] pin_oe;
    logic [15:0] rdata;
    logic write_strobe;
    logic read_strobe;
  } hpc_dev_s;

  typedef enum logic [1:0] {
    HPC_IDLE = 2'b00,
    HPC_ADDR = 2'b01,
    HPC_STRB = 2'b10,
    HPC_GAP = 2'b11
  } hpc_host_state_e;

  typedef enum logic [1:0] {
    HPC_WRITE = 2'b00,
    HPC_READ = 2'b01,
    HPC_VECTOR = 2'b10
  } hpc_kind_e;

  // Host end state, registered as a whole
  typedef struct packed {
    hpc_host_state_e st;
    hpc_kind_e kind;
    logic [3:0] cnt;
    logic [2:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [15:0] s1;
    logic [15:0] s2;
    logic [15:0] pin_o;
    logic [15:0] pin_oe;
    logic busy;
    logic done;
    logic txr;
    logic rxr;
  } hpc_host_s;

endpackage

// ===== hpc_if.sv
// Sixteen shared port pins between the device and the external host.
// Assumes an external pull-up: an undriven pin reads high.
`timescale 1ns/1ps
interface hpc_if;
  logic [15:0] dev_o;
  logic [15:0] dev_oe;
  logic [15:0] host_o;
  logic [15:0] host_oe;
  logic [15:0] pin;

  // Device wins when both drive; the far end must avoid that case
  assign pin = (dev_oe & dev_o) | (~dev_oe & host_oe & host_o) |
               (~dev_oe & ~host_oe);

  modport dev (output dev_o, output dev_oe, input pin);
  modport host (output host_o, output host_oe, input pin);
endinterface

// ===== hpc_device.sv
// Device end of the host port: pin role selection, strobe and select
// polarity, request drive, vector drive and general-purpose pins.
// Assumes the core reaches it over a plain register port on clock and
// the host obeys the strobe timing of the host end.
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`include "hpc_cfg.svh"

// Functional notes
// RL1: Single request pin: push-pull or open-drain by bit
// RL2: Both request pins: push-pull or open-drain by bit
// RL3: Data strobe polarity follows its bit
// RL4: Polarity covers combined or both separate strobes
// RL5: Address sampled while address strobe active
// RL6: Multiplexed mode latches low address/data bits
// RL7: Non-multiplexed mode uses dedicated address pins
// RL8: Single strobe plus read/write select
// RL9: Combined strobe qualifies, select gives direction
// RL10: Dual mode: separate read and write strobes
// RL11: Chip select polarity follows its bit
// RL12: Chip select polarity ignored when multiplexed
// RL13: Single request polarity follows its bit
// RL14: Both request pins share the polarity bit
// RL15: Vector driven while acknowledge is active
// RL16: Direction bit one outputs, zero inputs
// RL17: Unused host pins serve as general-purpose pins
// RL18: Port disabled makes every pin general-purpose
// RL19: Software changes modes only while disabled
// RL20: Output pin drives written data, reads back
// RL21: Open-drain request floats when not asserted
module hpc_device (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Host side pins
  hpc_if.dev lnk,
  // Core register port
  input wire logic [23:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Host access events toward the core
  output logic host_wr,
  output logic host_rd,
  output logic [2:0] host_addr,
  output logic [7:0] host_wdata
);

  hpc_pkg::hpc_dev_s r;
  hpc_pkg::hpc_dev_s n;

  // Control decodes
  logic en;
  logic mux;
  logic dds;
  logic drq;
  logic req_on;
  logic ack_on;
  logic [15:0] used;
  logic [15:0] gpio;
  logic sel;
  logic as_act;
  logic ds_act;
  logic rd_act;
  logic wr_act;
  logic ack_act;
  logic tx_a;
  logic rx_a;

  // Which pins the host interface claims under a given configuration
  function automatic logic [15:0] used_pins(input logic [15:0] c,
                                            input logic dq);
    logic [15:0] u;
    u = 16'h0000;
    if (c[`HPC_B_EN]) begin // RL18
      u[7:0] = 8'hFF;
      u[`HPC_P_RW] = 1'b1;
      u[`HPC_P_DS] = 1'b1;
      if (c[`HPC_B_MUX]) begin
        u[`HPC_P_AS] = 1'b1;
        u[9] = c[`HPC_B_A8EN]; // RL17
        u[10] = c[`HPC_B_A9EN]; // RL17
      end else begin
        u[10:8] = 3'h7;
      end
      u[`HPC_P_CS] = c[`HPC_B_CSEN]; // RL17
      u[`HPC_P_REQ] = c[`HPC_B_REN]; // RL17
      u[`HPC_P_ACK] = c[`HPC_B_REN] & (dq | c[`HPC_B_AEN]); // RL17
    end
    return u;
  endfunction

  // Level that an active signal shows for a polarity bit
  function automatic logic act_lvl(input logic on, input logic pol);
    return on ? pol : ~pol;
  endfunction

  assign en = r.ctrl[`HPC_B_EN];
  assign mux = r.ctrl[`HPC_B_MUX];
  assign dds = r.ctrl[`HPC_B_DDS];
  assign drq = r.aux[`HPC_AUX_DRQ];
  assign req_on = en & r.ctrl[`HPC_B_REN];
  assign ack_on = req_on & ~drq & r.ctrl[`HPC_B_AEN];
  assign used = used_pins(r.ctrl, drq);
  assign gpio = ~used;

  // Pin qualifiers, all from the second synchroniser stage
  assign sel = mux | ~r.ctrl[`HPC_B_CSEN] |
               (r.s2[`HPC_P_CS] == r.ctrl[`HPC_B_CSP]); // RL11 RL12
  assign as_act = r.s2[`HPC_P_AS] == r.ctrl[`HPC_B_ASP]; // RL5
  assign ds_act = r.s2[`HPC_P_DS] == r.ctrl[`HPC_B_DSP]; // RL3 RL4
  assign rd_act = en & sel & (dds ?
                  (r.s2[`HPC_P_RW] == r.ctrl[`HPC_B_DSP]) :
                  (ds_act & r.s2[`HPC_P_RW])); // RL8 RL9 RL10 RL4
  assign wr_act = en & sel & (dds ? ds_act :
                  (ds_act & ~r.s2[`HPC_P_RW])); // RL8 RL9 RL10
  assign ack_act = ack_on &
                   (r.s2[`HPC_P_ACK] == r.ctrl[`HPC_B_AP]); // RL15

  // In single request mode one pin carries either pending request
  assign tx_a = drq ? r.aux[`HPC_AUX_TXR] :
                (r.aux[`HPC_AUX_TXR] | r.aux[`HPC_AUX_RXR]);
  assign rx_a = r.aux[`HPC_AUX_RXR];

  // Next state: register port, pin sampling, host access, pin drive
  always_comb begin
    n = r;
    n.write_strobe = 1'b0;
    n.read_strobe = 1'b0;
    n.rdata = 16'h0000;

    // Core writes; mode bits are expected to move only while disabled
    if (reg_wr) begin // RL19
      case (reg_addr)
        `HPC_OFF_CTRL: n.ctrl = reg_wdata & `HPC_CTRL_MASK;
        `HPC_OFF_DIR: n.dir = reg_wdata; // RL16
        `HPC_OFF_DATA: n.dout = reg_wdata; // RL20
        `HPC_OFF_AUX: n.aux = reg_wdata & `HPC_AUX_MASK;
        `HPC_OFF_VEC: n.vec = reg_wdata[7:0];
        default: ;
      endcase
    end

    // Core reads, answered in the next cycle; unmapped reads give zero
    if (reg_rd) begin
      case (reg_addr)
        `HPC_OFF_CTRL: n.rdata = r.ctrl;
        `HPC_OFF_DIR: n.rdata = r.dir;
        `HPC_OFF_DATA: n.rdata = (r.dout & r.dir) | (r.s2 & ~r.dir); // RL20
        `HPC_OFF_AUX: n.rdata = r.aux;
        `HPC_OFF_VEC: n.rdata = {8'h00, r.vec};
        `HPC_OFF_STAT: n.rdata = {2'b00, ack_act, wr_act, rd_act,
                                  r.wbyte, r.addr};
        default: n.rdata = 16'h0000;
      endcase
    end

    // Pins come from another domain: two stages before any use
    n.s1 = lnk.pin;
    n.s2 = r.s1;

    // Address capture
    if (en && mux && as_act) begin
      n.addr = r.s2[2:0]; // RL5 RL6
    end else if (en && !mux && (rd_act || wr_act)) begin
      n.addr = r.s2[10:8]; // RL7
    end

    // Write data follows the bus until the strobe ends
    n.wr_d = wr_act;
    n.rd_d = rd_act;
    if (wr_act) begin
      n.wbyte = r.s2[7:0];
    end
    n.write_strobe = r.wr_d & ~wr_act; // Data is stable by the strobe's end
    n.read_strobe = rd_act & ~r.rd_d;

    // General-purpose drive, gated by the pin enable bit
    n.pin_o = r.dout; // RL20
    n.pin_oe = gpio & r.dir & {16{r.ctrl[`HPC_B_GEN]}}; // RL16 RL17 RL18

    // Data bus: vector fetch takes priority over a register read
    if (ack_act) begin
      n.pin_o[7:0] = r.vec; // RL15
      n.pin_oe[7:0] = 8'hFF;
    end else if (rd_act) begin
      n.pin_o[7:0] = r.aux[7:0];
      n.pin_oe[7:0] = 8'hFF;
    end

    // Request outputs; open drain floats the idle level
    if (req_on) begin
      n.pin_o[`HPC_P_REQ] = act_lvl(tx_a, r.ctrl[`HPC_B_RP]); // RL13 RL14
      n.pin_oe[`HPC_P_REQ] = ~r.ctrl[`HPC_B_ROD] | tx_a; // RL1 RL2 RL21
      if (drq) begin
        n.pin_o[`HPC_P_ACK] = act_lvl(rx_a, r.ctrl[`HPC_B_RP]); // RL14
        n.pin_oe[`HPC_P_ACK] = ~r.ctrl[`HPC_B_ROD] | rx_a; // RL2 RL21
      end
    end
  end

  // State register; every output comes from here
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      r <= '0;
      r.ctrl <= `HPC_CTRL_RST;
      r.dir <= `HPC_DIR_RST;
      r.aux <= `HPC_AUX_RST;
    end else begin
      r <= n;
    end
  end

  // Outputs straight from flip-flops
  assign lnk.dev_o = r.pin_o;
  assign lnk.dev_oe = r.pin_oe;
  assign reg_rdata = r.rdata;
  assign host_wr = r.write_strobe;
  assign host_rd = r.read_strobe;
  assign host_addr = r.addr;
  assign host_wdata = r.wbyte;

endmodule // hpc_device

// ===== hpc_host.sv
// Host end of the port: runs write, read and vector fetch cycles on the
// pins with the configured polarities and bus style.
// Assumes its configuration inputs match the device control register.
`timescale 1ns/1ps
`include "hpc_cfg.svh"

module hpc_host #(
  parameter int CLK_NS = `HPC_CLK_NS
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Pins toward the device
  hpc_if.host lnk,
  // Bus configuration, static during a cycle
  input wire logic cfg_mux,
  input wire logic cfg_dds,
  input wire logic cfg_drq,
  input wire logic cfg_dsp,
  input wire logic cfg_asp,
  input wire logic cfg_csp,
  input wire logic cfg_rp,
  input wire logic cfg_ap,
  // Command port
  input wire logic cmd_go,
  input wire logic [1:0] cmd_kind,
  input wire logic [2:0] cmd_addr,
  input wire logic [7:0] cmd_wdata,
  output logic busy,
  output logic done,
  output logic [7:0] rdata,
  // Decoded requests
  output logic tx_req,
  output logic rx_req
);

  // Phase length; must cover the device's sampling and drive latency
  localparam int PHASE_CYC = (`HPC_PHASE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] LAST = 4'(PHASE_CYC - 1);

  if (PHASE_CYC < 7 || PHASE_CYC > 16) begin : g_bad_phase
    $error("Phase length out of the range the counter serves");
  end

  hpc_pkg::hpc_host_s r;
  hpc_pkg::hpc_host_s n;
  logic strb;
  logic is_wr;
  logic is_rd;
  logic is_vec;

  // Sequencer and pin drive computed from the next state
  always_comb begin
    n = r;
    n.done = 1'b0;
    n.s1 = lnk.pin;
    n.s2 = r.s1;
    n.txr = r.s2[`HPC_P_REQ] == cfg_rp;
    n.rxr = cfg_drq & (r.s2[`HPC_P_ACK] == cfg_rp);
    case (r.st)
      hpc_pkg::HPC_IDLE: begin
        if (cmd_go) begin
          n.kind = hpc_pkg::hpc_kind_e'(cmd_kind);
          n.addr = cmd_addr;
          n.wdata = cmd_wdata;
          n.busy = 1'b1;
          n.cnt = 4'h0;
          n.st = (cfg_mux && cmd_kind != hpc_pkg::HPC_VECTOR) ?
                 hpc_pkg::HPC_ADDR : hpc_pkg::HPC_STRB;
        end
      end
      hpc_pkg::HPC_ADDR: begin
        n.cnt = r.cnt + 4'h1;
        if (r.cnt == LAST) begin
          n.cnt = 4'h0;
          n.st = hpc_pkg::HPC_STRB;
        end
      end
      hpc_pkg::HPC_STRB: begin
        n.cnt = r.cnt + 4'h1;
        if (r.cnt == LAST) begin
          if (r.kind != hpc_pkg::HPC_WRITE) begin
            n.rdata = r.s2[7:0];
          end
          n.cnt = 4'h0;
          n.st = hpc_pkg::HPC_GAP;
        end
      end
      hpc_pkg::HPC_GAP: begin
        n.cnt = r.cnt + 4'h1;
        if (r.cnt == LAST) begin
          n.busy = 1'b0;
          n.done = 1'b1;
          n.st = hpc_pkg::HPC_IDLE;
        end
      end
      default: n.st = hpc_pkg::HPC_IDLE;
    endcase

    // Decodes of the next phase, kept inside this process so that the
    // pin drive does not loop back through a separate assignment
    strb = n.st == hpc_pkg::HPC_STRB;
    is_wr = n.kind == hpc_pkg::HPC_WRITE;
    is_rd = n.kind == hpc_pkg::HPC_READ;
    is_vec = n.kind == hpc_pkg::HPC_VECTOR;

    // Strobes are owned by the host and idle at their inactive level
    n.pin_o = 16'h0000;
    n.pin_oe = 16'h0000;
    n.pin_oe[`HPC_P_RW] = 1'b1;
    n.pin_oe[`HPC_P_DS] = 1'b1;
    if (cfg_dds) begin
      n.pin_o[`HPC_P_RW] = (strb && is_rd) ? cfg_dsp : ~cfg_dsp; // RL10 RL3
      n.pin_o[`HPC_P_DS] = (strb && is_wr) ? cfg_dsp : ~cfg_dsp; // RL10 RL3
    end else begin
      n.pin_o[`HPC_P_RW] = ~is_wr; // RL8 RL9
      n.pin_o[`HPC_P_DS] = (strb && !is_vec) ? cfg_dsp : ~cfg_dsp; // RL9 RL3
    end

    // Address phase: multiplexed bus or dedicated lines with select
    if (cfg_mux) begin
      n.pin_oe[`HPC_P_AS] = 1'b1;
      n.pin_o[`HPC_P_AS] = (n.st == hpc_pkg::HPC_ADDR) ?
                           cfg_asp : ~cfg_asp; // RL5
      if (n.st == hpc_pkg::HPC_ADDR) begin
        n.pin_oe[7:0] = 8'hFF;
        n.pin_o[7:0] = {5'h00, n.addr};
      end
    end else begin
      n.pin_oe[11:8] = 4'hF;
      n.pin_o[10:8] = n.addr;
      n.pin_o[`HPC_P_CS] = (strb && !is_vec) ? cfg_csp : ~cfg_csp; // RL11
    end

    // Write data only while the strobe is active
    if (strb && is_wr) begin
      n.pin_oe[7:0] = 8'hFF;
      n.pin_o[7:0] = n.wdata;
    end

    // Acknowledge pin belongs to the host only in single request mode
    if (!cfg_drq) begin
      n.pin_oe[`HPC_P_ACK] = 1'b1;
      n.pin_o[`HPC_P_ACK] = (strb && is_vec) ? cfg_ap : ~cfg_ap;
    end
  end

  // State register
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign lnk.host_o = r.pin_o;
  assign lnk.host_oe = r.pin_oe;
  assign busy = r.busy;
  assign done = r.done;
  assign rdata = r.rdata;
  assign tx_req = r.txr;
  assign rx_req = r.rxr;

endmodule // hpc_host

// ===== hpc_monitor.sv
// Checker for the shared pins between the device and host ends.
// Assumes cfg_* mirror the device control bits while the port is enabled.
`timescale 1ns/1ps
module hpc_monitor (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Shared pins
  input wire logic [15:0] dev_o,
  input wire logic [15:0] dev_oe,
  input wire logic [15:0] host_o,
  input wire logic [15:0] host_oe,
  input wire logic [15:0] pin,
  // Host bus configuration
  input wire logic cfg_mux,
  input wire logic cfg_dds,
  input wire logic cfg_drq,
  input wire logic cfg_dsp,
  input wire logic cfg_asp,
  input wire logic cfg_csp,
  input wire logic cfg_ap
);
  logic [6:0] cfg_q;
  logic [1:0] age;
  logic settled, sel, read_on, wr_on, ack_on;
  wire [6:0] cfg_now = {cfg_mux, cfg_dds, cfg_drq, cfg_dsp, cfg_asp,
                        cfg_csp, cfg_ap};

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);

  // Idle pin levels lag a mode change, so all checks but a_no_fight judge only settled modes
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cfg_q <= 7'h00;
      age <= 2'h0;
    end else begin
      cfg_q <= cfg_now;
      age <= (cfg_now != cfg_q) ? 2'h0 : age + {1'b0, age != 2'h3};
    end
  end

  // Host strobe decode with the configured polarities
  assign settled = age == 2'h3;
  assign sel = cfg_mux || pin[11] == cfg_csp;
  assign read_on = settled && host_oe[12] && host_oe[13] && sel &&
    (cfg_dds ? pin[12] == cfg_dsp : pin[13] == cfg_dsp && pin[12]);
  assign wr_on = settled && host_oe[13] && sel &&
    (cfg_dds ? pin[13] == cfg_dsp : pin[13] == cfg_dsp && !pin[12]);
  assign ack_on = settled && !cfg_drq && host_oe[15] && pin[15] == cfg_ap;

  sequence s_read;
    read_on [*5];
  endsequence
  sequence s_ack;
    ack_on [*5];
  endsequence
  sequence s_write;
    wr_on [*2];
  endsequence

  a_read_drive: assert property (s_read |-> dev_oe[7:0] == 8'hFF)
    else $error("read data not driven");
  a_read_release: assert property ($fell(read_on) |-> ##5
    dev_oe[7:0] == 8'h00) else $error("read data not released");
  a_vector_drive: assert property (s_ack |-> dev_oe[7:0] == 8'hFF)
    else $error("vector not driven");
  a_vector_release: assert property ($fell(ack_on) |-> ##5
    dev_oe[7:0] == 8'h00) else $error("vector not released");
  a_no_fight: assert property ((dev_oe[7:0] & host_oe[7:0]) == 8'h00)
    else $error("both ends drive data");
  a_write_data: assert property (s_write |-> host_oe[7:0] == 8'hFF)
    else $error("write data missing");
  a_strobe_hold: assert property ($rose(wr_on) |-> wr_on [*8])
    else $error("write strobe too short");
  a_dual_excl: assert property (settled && cfg_dds && host_oe[12] &&
    host_oe[13] |-> !(pin[12] == cfg_dsp && pin[13] == cfg_dsp))
    else $error("both strobes active");
  a_mux_high: assert property (settled && cfg_mux |->
    !host_oe[9] && !host_oe[10]) else $error("host drives high address");
  a_addr_phase: assert property (settled && cfg_mux && host_oe[8] &&
    pin[8] == cfg_asp |-> host_oe[7:0] == 8'hFF)
    else $error("address missing under address strobe");
endmodule // hpc_monitor

// ===== hpc_tb.sv
// Self-checking bench: both ends joined by the pin interface.
// Assumes the register map and host timing of hpc_cfg.svh.
`timescale 1ns/1ps
`include "hpc_cfg.svh"
module testbench;
  logic clock, rst_b, reg_wr, reg_rd, host_wr, busy, done, tx_req, rx_req;
  logic cfg_mux, cfg_dds, cfg_drq, cfg_dsp, cfg_asp, cfg_csp, cfg_rp, cfg_ap;
  logic cmd_go, host_rd;
  logic [1:0] cmd_kind;
  logic [2:0] cmd_addr, host_addr;
  logic [7:0] cmd_wdata, host_wdata, rdata;
  logic [23:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, v;
  int n_fail = 0;
  int check_count = 0;
  int n_hwr = 0;
  int n_hrd = 0;
  hpc_if bus();

  hpc_device hpc_device_i (.clock(clock), .rst_b(rst_b), .lnk(bus.dev),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .host_wr(host_wr),
    .host_rd(host_rd),
    .host_addr(host_addr), .host_wdata(host_wdata));
  hpc_host hpc_host_i (.clock(clock), .rst_b(rst_b), .lnk(bus.host),
    .cfg_mux, .cfg_dds, .cfg_drq, .cfg_dsp, .cfg_asp, .cfg_csp, .cfg_rp,
    .cfg_ap, .cmd_go, .cmd_kind, .cmd_addr, .cmd_wdata, .busy, .done,
    .rdata, .tx_req, .rx_req);
  hpc_monitor hpc_monitor_i (.clock, .rst_b, .dev_o(bus.dev_o),
    .dev_oe(bus.dev_oe), .host_o(bus.host_o), .host_oe(bus.host_oe),
    .pin(bus.pin), .cfg_mux, .cfg_dds, .cfg_drq, .cfg_dsp, .cfg_asp,
    .cfg_csp, .cfg_ap);

  // Clock, 20 ns period
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // Count host write and read events seen by the core side
  always @(posedge clock) begin
    if (host_wr === 1'b1) n_hwr <= n_hwr + 1;
    if (host_rd === 1'b1) n_hrd <= n_hrd + 1;
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, got);
    check_count++;
    if (got !== e) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", nm, e, got);
    end
  endtask

  task automatic wreg(input logic [23:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rreg(input logic [23:0] a);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  task automatic settle();
    repeat (8) @(posedge clock);
    #1;
  endtask

  // One host cycle; the bound covers the longest multiplexed cycle
  task automatic hcmd(input logic [1:0] k, input logic [2:0] a,
                      input logic [7:0] d);
    int n;
    @(posedge clock);
    cmd_go <= 1'b1;
    cmd_kind <= k;
    cmd_addr <= a;
    cmd_wdata <= d;
    @(posedge clock);
    cmd_go <= 1'b0;
    n = 0;
    do begin
      @(posedge clock);
      #1 n++;
    end while (done !== 1'b1 && n < 60);
    chk("host done", 16'h0001, {15'h0000, done});
    chk("host busy", 16'h0000, {15'h0000, busy});
  endtask

  // One bus style: i[0] polarities, i[1] dual strobe and open drain, i[2] mux
  task automatic run(input logic [2:0] i);
    logic p, dds, mux;
    logic [15:0] m;
    int h;
    p = i[0];
    dds = i[1];
    mux = i[2];
    m = {p, p, p, dds, mux, p, p, dds, 8'h3F};
    wreg(`HPC_OFF_CTRL, m);
    {cfg_ap, cfg_rp, cfg_csp, cfg_dds, cfg_mux, cfg_asp, cfg_dsp} <= m[15:9];
    // Old idle levels must leave the synchronisers before enabling
    settle();
    wreg(`HPC_OFF_CTRL, m | 16'h0040);
    rreg(`HPC_OFF_CTRL);
    chk("control", m | 16'h0040, v);
    wreg(`HPC_OFF_AUX, {8'h00, 8'hC0 | i});
    h = n_hwr;
    hcmd(hpc_pkg::HPC_WRITE, i, 8'h30 + i);
    chk("write count", 16'(h + 1), 16'(n_hwr));
    chk("host address", {13'h0000, i}, {13'h0000, host_addr});
    chk("host data", {8'h00, 8'h30 + i}, {8'h00, host_wdata});
    rreg(`HPC_OFF_STAT);
    chk("status", {5'h00, 8'h30 + i, i}, v);
    h = n_hrd;
    hcmd(hpc_pkg::HPC_READ, ~i, 8'h00);
    chk("read byte", {8'h00, 8'hC0 | i}, {8'h00, rdata});
    chk("read count", 16'(h + 1), 16'(n_hrd));
    wreg(`HPC_OFF_VEC, {8'h00, 8'h90 + i});
    hcmd(hpc_pkg::HPC_VECTOR, 3'h0, 8'h00);
    chk("vector", {8'h00, 8'h90 + i}, {8'h00, rdata});
    wreg(`HPC_OFF_AUX, 16'h0200);
    settle();
    chk("tx flag", 16'h0001, {15'h0000, tx_req});
    chk("request pin", {15'h0000, p}, {15'h0000, bus.pin[14]});
    wreg(`HPC_OFF_AUX, 16'h0000);
    settle();
    chk("idle request", {15'h0000, dds | ~p}, {15'h0000, bus.pin[14]});
    chk("request drive", {15'h0000, ~dds}, {15'h0000, bus.dev_oe[14]});
    wreg(`HPC_OFF_AUX, 16'h0500);
    cfg_drq <= 1'b1;
    settle();
    chk("rx pin", {15'h0000, p}, {15'h0000, bus.pin[15]});
    chk("rx flag", 16'h0001, {15'h0000, rx_req});
    wreg(`HPC_OFF_AUX, 16'h0000);
    cfg_drq <= 1'b0;
    cfg_csp <= ~p;
    settle();
    h = n_hwr;
    hcmd(hpc_pkg::HPC_WRITE, 3'h5, 8'hE0);
    chk("unselected write", 16'(h + int'(mux)), 16'(n_hwr));
    wreg(`HPC_OFF_CTRL, m);
    cfg_csp <= p;
  endtask

  // Main sequence: reset values, general-purpose pins, then each bus style
  initial begin
    logic [23:0] offs [4];
    offs = '{`HPC_OFF_CTRL, `HPC_OFF_DIR, `HPC_OFF_AUX, 24'hFFFFC0};
    rst_b = 1'b0;
    {reg_wr, reg_rd, cmd_go, cfg_mux, cfg_dds, cfg_drq} = 6'h00;
    {cfg_dsp, cfg_asp, cfg_csp, cfg_rp, cfg_ap} = 5'h00;
    {reg_addr, reg_wdata, cmd_kind, cmd_addr, cmd_wdata} = 53'h0;
    repeat (16) @(posedge clock);
    rst_b <= 1'b1;
    foreach (offs[k]) begin
      rreg(offs[k]);
      chk("reset value", `HPC_CTRL_RST, v);
    end
    wreg(`HPC_OFF_CTRL, 16'h0081);
    rreg(`HPC_OFF_CTRL);
    chk("reserved bit", 16'h0001, v);
    wreg(`HPC_OFF_DIR, 16'h0F0F);
    wreg(`HPC_OFF_DATA, 16'hA5C3);
    settle();
    chk("gpio pins", 16'h0503, bus.pin & 16'h0F0F);
    rreg(`HPC_OFF_DATA);
    chk("gpio readback", 16'h05F3, v & 16'h0FFF);
    wreg(`HPC_OFF_DIR, 16'h0000);
    wreg(`HPC_OFF_CTRL, 16'h0000);
    for (int i = 0; i < 8; i++) run(3'(i));
    end_of_test();
  end

  // Watchdog, far beyond the 1200 or so cycles the sequence needs
  initial begin
    repeat (30000) @(posedge clock);
    n_fail++;
    end_of_test();
  end
endmodule // testbench
